// ---- inc/ep_event_if.sv ----
`timescale 1ns/1ps
interface ep_event_if;
  logic access_pulse;
  logic [1:0] access_ep;
  logic strobe;
  logic [3:0] flags;
  logic clear_wr;
  logic [3:0] clear_data;

  modport tracker (
    input access_pulse,
    input access_ep,
    input clear_wr,
    input clear_data,
    output strobe,
    output flags
  );

  modport user (
    output access_pulse,
    output access_ep,
    output clear_wr,
    output clear_data,
    input strobe,
    input flags
  );
endinterface : ep_event_if

// ---- inc/sie_ep_cfg.svh ----
`ifndef SIE_EP_CFG_SVH
`define SIE_EP_CFG_SVH

`define ADDR_PIPE_DIR 8'h41
`define ADDR_DEV_ADDR 8'h42
`define ADDR_HALT 8'h43
`define ADDR_STATUS 8'h45
`define ADDR_EP_EN 8'h47

`define RST_PIPE_DIR 8'h0e
`define RST_HALT 8'h0e
`define RST_EP_EN 8'h0f
`define RST_DEV_ADDR 8'h00

`define ST_NAK_MASK 7
`define ST_XFER_END 6
`define ST_CRC 5
`define ST_NAK 4
`define ST_IN 3
`define ST_OUT 2
`define ST_FIFO0_ERR 1
`define ST_ADRSET 0

`define EP_BITS_MASK 8'h0f

`endif

// ---- inc/sie_ep_pkg.sv ----
package sie_ep_pkg;

  typedef enum logic [1:0] {
    TOG_IDLE = 2'b00,
    TOG_LOW = 2'b01
  } toggle_state_t;

  typedef logic [3:0] ep_vec_t;

endpackage : sie_ep_pkg

// ---- logic/ep_access_tracker.sv ----
`timescale 1ns/1ps
module ep_access_tracker (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  ep_event_if.tracker ev
);

  logic [3:0] flags_r;
  logic strobe_r;

  // Flag only the endpoint actually addressed; set wins over clear
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      flags_r <= 4'h0;
    else
    begin
      logic [3:0] nxt;
      nxt = flags_r;
      if (ev.clear_wr)
        nxt = nxt & ev.clear_data;
      if (ev.access_pulse)
        nxt[ev.access_ep] = 1'b1;
      flags_r <= nxt;
    end
  end

  // Strobe registered on the same edge the flag lands, so firmware sees it set
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      strobe_r <= 1'b0;
    else
      strobe_r <= ev.access_pulse;
  end

  assign ev.flags = flags_r;
  assign ev.strobe = strobe_r;

endmodule : ep_access_tracker

// ---- logic/sie_ep_status_ctrl.sv ----
`timescale 1ns/1ps
`include "sie_ep_cfg.svh"

module sie_ep_status_ctrl (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Firmware data-memory port
  input wire logic [7:0] mem_addr_i,
  input wire logic mem_wr_i,
  input wire logic [7:0] mem_wdata_i,
  output logic [7:0] mem_rdata_o,
  // Engine events, same clock
  input wire logic tok_access_i,
  input wire logic [1:0] tok_ep_i,
  input wire logic tok_in_i,
  input wire logic out_data_rx_i,
  input wire logic setup_rx_i,
  input wire logic nak_sent_i,
  input wire logic crc_err_i,
  input wire logic ep_zero_fifo_error_i,
  input wire logic in_done_i,
  input wire logic eot_i,
  // Controls toward the engine
  output logic endpoint_activity_strobe_o,
  output logic [3:0] ep_access_o,
  output logic [3:0] ep_dir_in_o,
  output logic [3:0] ep_halt_o,
  output logic [3:0] ep_enable_o,
  output logic toggle_reset_o,
  output logic [6:0] dev_addr_o,
  output logic remote_wakeup_o,
  output logic nak_irq_o
);

  logic [7:0] pipe_dir_r;
  logic [7:0] halt_r;
  logic [7:0] ep_en_r;
  logic [7:0] device_address_reg_r;
  logic [6:0] dev_addr_r;
  logic nak_irq_mask_r;
  logic crc_err_r;
  logic out_flag_r;
  logic ep_zero_fifo_error_r;
  logic adr_set_r;
  logic in_flag_r;
  logic nak_flag_r;
  logic end_of_transfer_state_r;
  logic nak_irq_r;
  logic [7:0] rdata_r;
  sie_ep_pkg::toggle_state_t tog_state_r;
  logic toggle_reset_r;

  ep_event_if ev ();

  function automatic logic wr_hit(input logic [7:0] a);
    wr_hit = mem_wr_i && (mem_addr_i == a);
  endfunction : wr_hit

  // Clear only on written zero; a concurrent set wins
  function automatic logic flag_nxt(input logic cur, input logic set,
                                    input logic wr, input logic bitv);
    logic v;
    v = cur;
    if (wr && !bitv)
      v = 1'b0;
    if (set)
      v = 1'b1;
    flag_nxt = v;
  endfunction : flag_nxt

  assign ev.access_pulse = tok_access_i;
  assign ev.access_ep = tok_ep_i;
  // A new token replaces the flags, so only the latest endpoint shows
  assign ev.clear_wr = tok_access_i;
  assign ev.clear_data = 4'h0;

  ep_access_tracker u_tracker (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .ev(ev)
  );

  // Control registers; reserved upper bits held at zero
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pipe_dir_r <= `RST_PIPE_DIR;
      halt_r <= `RST_HALT;
      ep_en_r <= `RST_EP_EN;
    end
    else
    begin
      if (wr_hit(`ADDR_PIPE_DIR))
        pipe_dir_r <= mem_wdata_i & `EP_BITS_MASK;
      if (wr_hit(`ADDR_HALT))
        halt_r <= mem_wdata_i & `EP_BITS_MASK;
      if (wr_hit(`ADDR_EP_EN))
        ep_en_r <= mem_wdata_i & `EP_BITS_MASK;
    end
  end

  // Toggle reset follows bit 0 while low; firmware owns the minimum width
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      tog_state_r <= sie_ep_pkg::TOG_IDLE;
      toggle_reset_r <= 1'b0;
    end
    else
    begin
      case (tog_state_r)
        sie_ep_pkg::TOG_IDLE:
        begin
          toggle_reset_r <= 1'b0;
          if (!pipe_dir_r[0])
          begin
            tog_state_r <= sie_ep_pkg::TOG_LOW;
            toggle_reset_r <= 1'b1;
          end
        end
        sie_ep_pkg::TOG_LOW:
        begin
          toggle_reset_r <= !pipe_dir_r[0];
          if (pipe_dir_r[0])
            tog_state_r <= sie_ep_pkg::TOG_IDLE;
        end
        default:
        begin
          tog_state_r <= sie_ep_pkg::TOG_IDLE;
          toggle_reset_r <= 1'b0;
        end
      endcase
    end
  end

  // Address register and the address actually used on the bus
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      device_address_reg_r <= `RST_DEV_ADDR;
    else if (wr_hit(`ADDR_DEV_ADDR))
      device_address_reg_r <= mem_wdata_i;
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      dev_addr_r <= 7'h00;
    else if (wr_hit(`ADDR_DEV_ADDR) && !adr_set_r)
      dev_addr_r <= mem_wdata_i[7:1];
    else if (adr_set_r && in_done_i)
      dev_addr_r <= device_address_reg_r[7:1];
  end

  // Deferred-address bit: firmware writes it, engine clears after use
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      adr_set_r <= 1'b0;
    else if (wr_hit(`ADDR_STATUS))
      adr_set_r <= mem_wdata_i[`ST_ADRSET];
    else if (adr_set_r && in_done_i)
      adr_set_r <= 1'b0;
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      nak_irq_mask_r <= 1'b0;
    else if (wr_hit(`ADDR_STATUS))
      nak_irq_mask_r <= mem_wdata_i[`ST_NAK_MASK];
  end

  // Sticky error and data flags
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      crc_err_r <= 1'b0;
      ep_zero_fifo_error_r <= 1'b0;
      out_flag_r <= 1'b0;
    end
    else
    begin
      crc_err_r <= flag_nxt(crc_err_r, crc_err_i, wr_hit(`ADDR_STATUS),
                            mem_wdata_i[`ST_CRC]);
      ep_zero_fifo_error_r <= flag_nxt(ep_zero_fifo_error_r, ep_zero_fifo_error_i,
                                       wr_hit(`ADDR_STATUS),
                                       mem_wdata_i[`ST_FIFO0_ERR]);
      // SETUP clear loses to a fresh OUT in the same cycle
      out_flag_r <= flag_nxt(out_flag_r && !setup_rx_i, out_data_rx_i,
                             wr_hit(`ADDR_STATUS),
                             mem_wdata_i[`ST_OUT]);
    end
  end

  // Read-only state mirrored from the engine
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      in_flag_r <= 1'b0;
      nak_flag_r <= 1'b0;
      end_of_transfer_state_r <= 1'b1;
    end
    else
    begin
      if (tok_access_i)
        in_flag_r <= tok_in_i;
      if (tok_access_i)
        nak_flag_r <= 1'b0;
      if (nak_sent_i)
        nak_flag_r <= 1'b1;
      end_of_transfer_state_r <= eot_i;
    end
  end

  // One-cycle NAK request unless masked
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      nak_irq_r <= 1'b0;
    else
      nak_irq_r <= nak_sent_i && !nak_irq_mask_r;
  end

  // Registered read data; unmapped addresses read zero
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rdata_r <= 8'h00;
    else
    begin
      case (mem_addr_i)
        `ADDR_PIPE_DIR: rdata_r <= pipe_dir_r;
        `ADDR_DEV_ADDR: rdata_r <= device_address_reg_r;
        `ADDR_HALT: rdata_r <= halt_r;
        `ADDR_EP_EN: rdata_r <= ep_en_r;
        `ADDR_STATUS: rdata_r <= {nak_irq_mask_r, end_of_transfer_state_r,
                                  crc_err_r, nak_flag_r, in_flag_r,
                                  out_flag_r, ep_zero_fifo_error_r,
                                  adr_set_r};
        default: rdata_r <= 8'h00;
      endcase
    end
  end

  assign mem_rdata_o = rdata_r;
  assign endpoint_activity_strobe_o = ev.strobe;
  assign ep_access_o = ev.flags;
  // Endpoint 0 direction is fixed by control transfers; bit 0 is the toggle
  assign ep_dir_in_o = {pipe_dir_r[3:1], 1'b1};
  assign ep_halt_o = halt_r[3:0];
  assign ep_enable_o = {ep_en_r[3:1], 1'b1};
  assign toggle_reset_o = toggle_reset_r;
  assign dev_addr_o = dev_addr_r;
  assign remote_wakeup_o = device_address_reg_r[0];
  assign nak_irq_o = nak_irq_r;

endmodule : sie_ep_status_ctrl

// ---- verification/ep_status_checker.sv ----
`timescale 1ns/1ps
module ep_status_checker (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] mem_addr_i,
  input wire logic mem_wr_i,
  input wire logic [7:0] mem_wdata_i,
  input wire logic tok_access_i,
  input wire logic [1:0] tok_ep_i,
  input wire logic nak_sent_i,
  input wire logic endpoint_activity_strobe_o,
  input wire logic [3:0] ep_access_o,
  input wire logic [3:0] ep_dir_in_o,
  input wire logic [3:0] ep_halt_o,
  input wire logic [3:0] ep_enable_o,
  input wire logic toggle_reset_o,
  input wire logic remote_wakeup_o,
  input wire logic nak_irq_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  logic wr_dir, wr_halt, wr_en, wr_addr;
  assign wr_dir = mem_wr_i && mem_addr_i == 8'h41;
  assign wr_addr = mem_wr_i && mem_addr_i == 8'h42;
  assign wr_halt = mem_wr_i && mem_addr_i == 8'h43;
  assign wr_en = mem_wr_i && mem_addr_i == 8'h47;
  a_strobe_on_token: assert property (
    tok_access_i |=> endpoint_activity_strobe_o) else $error("no strobe");
  a_strobe_only_token: assert property (
    !tok_access_i |=> !endpoint_activity_strobe_o) else $error("stray strobe");
  a_access_flag_set: assert property (
    tok_access_i |=> ep_access_o[$past(tok_ep_i)]) else $error("access flag");
  a_irq_only_nak: assert property (
    !nak_sent_i |=> !nak_irq_o) else $error("stray irq");
  a_toggle_from_bit: assert property (
    wr_dir |=> ##1 toggle_reset_o == !$past(mem_wdata_i[0], 2)) else $error("toggle reset");
  a_dir_from_write: assert property (
    wr_dir |=> ep_dir_in_o == {$past(mem_wdata_i[3:1]), 1'b1}) else $error("direction");
  a_halt_from_write: assert property (
    wr_halt |=> ep_halt_o == $past(mem_wdata_i[3:0])) else $error("halt");
  a_enable_from_write: assert property (
    wr_en |=> ep_enable_o == {$past(mem_wdata_i[3:1]), 1'b1}) else $error("enable");
  a_wakeup_from_write: assert property (
    wr_addr |=> remote_wakeup_o == $past(mem_wdata_i[0])) else $error("wake-up bit");
  c_token: cover property (tok_access_i);
  c_wake: cover property (wr_addr && mem_wdata_i[0]);
  c_irq: cover property (nak_irq_o);
  c_toggle: cover property (wr_dir && !mem_wdata_i[0]);
endmodule : ep_status_checker

bind sie_ep_status_ctrl ep_status_checker chk (
  .core_clk_i(core_clk_i),
  .rst_b_i(rst_b_i),
  .mem_addr_i(mem_addr_i),
  .mem_wr_i(mem_wr_i),
  .mem_wdata_i(mem_wdata_i),
  .tok_access_i(tok_access_i),
  .tok_ep_i(tok_ep_i),
  .nak_sent_i(nak_sent_i),
  .endpoint_activity_strobe_o(endpoint_activity_strobe_o),
  .ep_access_o(ep_access_o),
  .ep_dir_in_o(ep_dir_in_o),
  .ep_halt_o(ep_halt_o),
  .ep_enable_o(ep_enable_o),
  .toggle_reset_o(toggle_reset_o),
  .remote_wakeup_o(remote_wakeup_o),
  .nak_irq_o(nak_irq_o)
);

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
module testbench;
  logic core_clk_i, rst_b_i, mem_wr_i, pend, pend_d, tog, tok_in, end_of_transfer_state;
  logic [7:0] mem_addr_i, mem_wdata_i, rdata, got, d, e, f;
  logic [6:0] ev, dev_addr;
  logic [1:0] tok_ep;
  logic [3:0] acc, halt, dir, en;
  logic nak_cnt_p;
  logic [9:0] n;
  logic [9:0] q [$];
  int miscompares, n_tests, nak_cnt, cyc;
  initial
  begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  usb_host_model host (.core_clk_i(core_clk_i), .ev_o(ev), .tok_ep_o(tok_ep),
    .tok_in_o(tok_in), .eot_o(end_of_transfer_state));
  sie_ep_status_ctrl dut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .mem_addr_i(mem_addr_i), .mem_wr_i(mem_wr_i), .mem_wdata_i(mem_wdata_i),
    .mem_rdata_o(rdata), .tok_access_i(ev[0]), .tok_ep_i(tok_ep), .tok_in_i(tok_in),
    .out_data_rx_i(ev[1]), .setup_rx_i(ev[2]), .nak_sent_i(ev[3]), .crc_err_i(ev[4]),
    .ep_zero_fifo_error_i(ev[5]), .in_done_i(ev[6]), .eot_i(end_of_transfer_state),
    .endpoint_activity_strobe_o(), .ep_access_o(acc), .ep_dir_in_o(dir), .ep_halt_o(halt),
    .ep_enable_o(en), .toggle_reset_o(tog), .dev_addr_o(dev_addr), .remote_wakeup_o(),
    .nak_irq_o(nak_cnt_p));
  task automatic chk(input string what, input logic [7:0] x, input logic [7:0] y);
    n_tests++;
    if (y !== x)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, x, y);
    end
  endtask : chk
  task automatic test_done;
    if (q.size() != 0)
      miscompares++;
    $display("compared %0d mismatched %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk_i);
    mem_addr_i <= a;
    mem_wdata_i <= v;
    mem_wr_i <= 1'b1;
    @(posedge core_clk_i);
    mem_wr_i <= 1'b0;
  endtask : wr
  // View 0 read data, 1 toggle and address, 2 access and halt, 3 direction and enable
  task automatic note(input logic [1:0] s, input logic [7:0] a, input logic [7:0] x);
    @(posedge core_clk_i);
    mem_addr_i <= a;
    pend <= 1'b1;
    q.push_back({s, x});
    @(posedge core_clk_i);
    pend <= 1'b0;
  endtask : note
  // Read data lags its address by one edge; looked at on the falling edge, once settled
  always @(negedge core_clk_i)
  begin
    nak_cnt += nak_cnt_p;
    if (pend_d)
    begin
      n = q.pop_front();
      got = n[9:8] == 2'd0 ? rdata : n[9:8] == 2'd1 ? {tog, dev_addr} :
            n[9:8] == 2'd2 ? {acc, halt} : {dir, en};
      chk($sformatf("view%0d", n[9:8]), n[7:0], got);
    end
  end
  always @(posedge core_clk_i)
  begin
    cyc++;
    pend_d <= pend;
    if (cyc > 2000)
    begin
      miscompares++;
      test_done();
    end
  end
  initial
  begin
    rst_b_i = 1'b0;
    mem_addr_i = 8'h00;
    mem_wr_i = 1'b0;
    mem_wdata_i = 8'h00;
    pend = 1'b0;
    pend_d = 1'b0;
    {miscompares, n_tests, nak_cnt, cyc} = 0;
    void'($urandom(26));
    repeat (10) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    note(0, 8'h41, 8'h0e);
    note(0, 8'h47, 8'h0f);
    note(0, 8'h43, 8'h0e);
    note(0, 8'h42, 8'h00);
    note(0, 8'h45, 8'h40);
    note(0, 8'h44, 8'h00);
    $display("reset test over");
    host.send(4, 0, 0);
    host.send(5, 0, 0);
    host.send(1, 0, 0);
    note(0, 8'h45, 8'h66);
    wr(8'h45, 8'hdb);
    note(0, 8'h45, 8'hc3);
    host.send(1, 0, 0);
    note(0, 8'h45, 8'hc7);
    host.send(2, 0, 0);
    host.send(3, 0, 0);
    note(0, 8'h45, 8'hd3);
    host.send(0, 2, 1);
    note(0, 8'h45, 8'hcb);
    note(2, 8'h00, 8'h4e);
    $display("status test over");
    wr(8'h42, 8'ha5);
    note(0, 8'h42, 8'ha5);
    note(1, 8'h00, 8'h80);
    host.send(6, 0, 0);
    note(1, 8'h00, 8'hd2);
    note(0, 8'h45, 8'hca);
    wr(8'h45, 8'h00);
    wr(8'h42, 8'h36);
    host.send(3, 0, 0);
    note(0, 8'h45, 8'h58);
    note(2, 8'h00, 8'h4e);
    chk("irq count", 8'h01, nak_cnt[7:0]);
    d = 8'($urandom);
    e = 8'($urandom);
    f = 8'($urandom);
    d[0] = 1'b0;
    wr(8'h41, d);
    wr(8'h43, e);
    wr(8'h47, f);
    note(0, 8'h41, {4'h0, d[3:0]});
    note(0, 8'h43, {4'h0, e[3:0]});
    note(0, 8'h47, {4'h0, f[3:0]});
    note(3, 8'h00, {d[3:1], 1'b1, f[3:1], 1'b1});
    note(1, 8'h00, 8'h9b);
    // Toggle reset held high well past the minimum before release
    repeat (10) @(posedge core_clk_i);
    wr(8'h41, {d[7:1], 1'b1});
    note(1, 8'h00, 8'h1b);
    host.set_eot(1'b0);
    note(0, 8'h45, 8'h18);
    host.set_eot(1'b1);
    $display("address test over");
    repeat (2) @(posedge core_clk_i);
    rst_b_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    note(0, 8'h45, 8'h40);
    note(0, 8'h42, 8'h00);
    note(1, 8'h00, 8'h80);
    note(2, 8'h00, 8'h0e);
    repeat (3) @(posedge core_clk_i);
    $display("second reset test over");
    test_done();
  end
endmodule : testbench

// ---- verification/usb_host_model.sv ----
`timescale 1ns/1ps
module usb_host_model (
  input wire logic core_clk_i,
  output logic [6:0] ev_o,
  output logic [1:0] tok_ep_o,
  output logic tok_in_o,
  output logic eot_o
);
  // Event bits: token, out data, setup, nak, crc, fifo0 error, in done
  initial
  begin
    ev_o = 7'h00;
    tok_ep_o = 2'h0;
    tok_in_o = 1'b0;
    eot_o = 1'b1;
  end
  task automatic send(input int k, input logic [1:0] ep, input logic dir_in);
    @(posedge core_clk_i);
    ev_o[k] <= 1'b1;
    tok_ep_o <= ep;
    tok_in_o <= dir_in;
    @(posedge core_clk_i);
    ev_o <= 7'h00;
    // Inverted leftovers so a stale token field never matches the one just sent
    tok_ep_o <= ~ep;
    tok_in_o <= ~dir_in;
  endtask : send
  task automatic set_eot(input logic v);
    @(posedge core_clk_i);
    eot_o <= v;
  endtask : set_eot
endmodule : usb_host_model
